/* rtl/amcg_pkg.sv */
/*
  Shared constants for the converter mode, clock/channel and gain register bank:
  register indices, reset values, writable-bit masks, field positions and codes.
  Assumes a Wishbone byte address where a register index maps to index * 4.
*/
package amcg_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0]  IDX_STATUS     = 6'h01;
  localparam logic [5:0]  IDX_MODE       = 6'h02;
  localparam logic [5:0]  IDX_CLOCK      = 6'h03;
  localparam logic [5:0]  IDX_GAIN       = 6'h04;
  localparam logic [5:0]  IDX_IRQ_STAT   = 6'h10;
  localparam logic [5:0]  IDX_IRQ_MASK   = 6'h11;
  localparam int          IDX_LSB        = 2;
  localparam int          IDX_MSB        = 7;

  localparam int          REG_W          = 16;
  localparam logic [15:0] MODE_RST       = 16'h0510;
  localparam logic [15:0] CLOCK_RST      = 16'h0f8e;
  localparam logic [15:0] GAIN_RST       = 16'h0000;

  // Bits that software may change; all others stay zero
  localparam logic [15:0] MODE_WMASK     = 16'h3f12;
  localparam logic [15:0] CLOCK_WMASK    = 16'h0f9f;
  localparam logic [15:0] GAIN_WMASK     = 16'h7777;
  localparam logic [3:0]  CLOCK_RSVD_HI  = 4'h0;

  // Interface-mode fields
  localparam int          MODE_REGCRC    = 13;
  localparam int          MODE_RXCRC     = 12;
  localparam int          MODE_CRCTYPE   = 11;
  localparam int          MODE_RSTSEEN   = 10;
  localparam int          MODE_WLEN_LSB  = 8;
  localparam int          MODE_TIMEOUT   = 4;
  localparam int          MODE_FLOAT     = 1;

  // Clock/channel fields
  localparam int          CLK_CHEN_LSB   = 8;
  localparam int          CLK_SEL        = 7;
  localparam int          CLK_OSR_LSB    = 2;
  localparam int          CLK_PWR_LSB    = 0;
  localparam logic [14:0] OSR_BASE       = 15'h0080;

  // Gain fields: one 3-bit code per channel, 4 bits apart
  localparam int          GAIN_STRIDE    = 4;
  localparam int          NUM_CH         = 4;

  // Status mirror: crc type, reset flag and word length at bits 11:8
  localparam int          STAT_MIR_LSB   = 8;

  typedef enum logic [1:0] {
    WL_16      = 2'h0,
    WL_24      = 2'h1,
    WL_32_PAD  = 2'h2,
    WL_32_SEXT = 2'h3
  } amcg_wlen_e;

  localparam logic [5:0]  WBITS_16       = 6'h10;
  localparam logic [5:0]  WBITS_24       = 6'h18;
  localparam logic [5:0]  WBITS_32       = 6'h20;

  // Interrupt event bits
  localparam int          EV_W           = 3;
  localparam int          EV_MODE        = 0;
  localparam int          EV_CLOCK       = 1;
  localparam int          EV_GAIN        = 2;

endpackage

/* rtl/amcg_regs.sv */
/*
  Configuration register bank of a four-channel delta-sigma converter: interface
  mode, clock/channel and gain registers, a status mirror, write-event interrupts
  and the idle drive of the data-ready pin, all reached over a classic Wishbone
  slave. Assumes one clock, synchronous active-high reset, and a conversion-data
  flag produced by logic on the same clock.
*/
// Chosen here: the Wishbone register port.
// Summary of operation
// - Interface-mode register at index 02h, reset value 0510h.
// - Mode bit 13 enables register-map CRC; resets to 0.
// - Mode bit 12 enables CRC check on incoming frames; resets to 0.
// - Mode bit 11 picks CRC polynomial: 0 CCITT, 1 ANSI.
// - Mode bit 10 reads 1 after reset; writing 0 clears it.
// - Mode bits 9:8 pick output word length; default 24 bits.
// - Mode bit 4 enables the serial timeout; resets to 1.
// - Mode bit 1: idle data-ready pin driven high or floated.
// - Clock/channel register at index 03h, reset 0F8Eh, bits 15:12 read zero.
// - Bits 11:8 enable converters of channels 3..0; reset enabled.
// - Bit 7 picks clock source: 0 internal, 1 external; resets to 1.
// - Bits 4:2 set oversampling ratio 128 shl code; reset code 011b.
// - Bits 1:0 power mode; 10b and 11b both high resolution; reset 10b.
// - Gain register at index 04h, reset 0000h, unity gain.
// - Three-bit gain code per channel at 14:12, 10:8, 6:4, 2:0.
// - Status mirrors CRC polynomial, reset flag and word length.
`timescale 1ns/100ps

module amcg_regs #(
  parameter int ADR_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             wbCycI,
  input  wire logic             wbStbI,
  input  wire logic             wbWeI,
  input  wire logic [ADR_W-1:0] wbAdrI,
  input  wire logic [3:0]       wbSelI,
  input  wire logic [31:0]      wbDatI,
  output logic      [31:0]      wbDatO,
  output logic                  wbAckO,
  input  wire logic             convDataAvail,
  output logic                  dataReadyPinO,
  output logic                  dataReadyPinOe,
  output logic                  regCrcOn,
  output logic                  rxCrcOn,
  output logic                  crcPolyAnsi,
  output logic                  resetSeen,
  output logic      [1:0]       wordLengthSelect,
  output logic      [5:0]       wordBits,
  output logic                  timeoutOn,
  output logic                  readyPinFloatSelect,
  output logic                  channel0ConverterOn,
  output logic                  channel1ConverterOn,
  output logic                  channel2ConverterOn,
  output logic                  channel3ConverterOn,
  output logic                  extClockSelect,
  output logic      [2:0]       oversamplingRatio,
  output logic      [14:0]      osrValue,
  output logic      [1:0]       powerModeSelect,
  output logic                  highResolution,
  output logic      [2:0]       ampGainCh0,
  output logic      [2:0]       ampGainCh1,
  output logic      [2:0]       ampGainCh2,
  output logic      [2:0]       ampGainCh3,
  output logic                  irq
);

  if (ADR_W < amcg_pkg::IDX_MSB + 1)
  begin : g_chkAdr
    $error("ADR_W too narrow for the register map");
  end

  logic [15:0]            mode_q;
  logic [15:0]            mode_d;
  logic [15:0]            clock_q;
  logic [15:0]            clock_d;
  logic [15:0]            gain_q;
  logic [15:0]            gain_d;
  logic [amcg_pkg::EV_W-1:0] irqStat_q;
  logic [amcg_pkg::EV_W-1:0] irqStat_d;
  logic [amcg_pkg::EV_W-1:0] irqMask_q;
  logic [amcg_pkg::EV_W-1:0] events;
  logic [31:0]            rdData;
  logic [31:0]            wbDat_q;
  logic                   ack_q;
  logic [14:0]            osr_q;
  logic [5:0]             wbits_q;
  logic [5:0]             wbits_d;
  logic                   rdyO_q;
  logic                   rdyOe_q;
  logic                   irq_q;
  logic [5:0]             idx;
  logic                   take;
  logic                   wrMode;
  logic                   wrClock;
  logic                   wrGain;
  logic                   wrIrqStat;
  logic                   wrIrqMask;

  // Byte-lane merge that keeps bits outside the writable mask at their old value
  function automatic logic [15:0] amcgMerge(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [3:0]  sel,
    input logic [15:0] wmask
  );
    logic [15:0] laneMask;
    laneMask = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old & ~laneMask) | (wdat[15:0] & laneMask);
  endfunction

  assign idx       = wbAdrI[amcg_pkg::IDX_MSB:amcg_pkg::IDX_LSB];
  // Request taken on the first cycle it is seen; ack blocks a double take
  assign take      = wbCycI && wbStbI && !ack_q;
  assign wrMode    = take && wbWeI && (idx == amcg_pkg::IDX_MODE);
  assign wrClock   = take && wbWeI && (idx == amcg_pkg::IDX_CLOCK);
  assign wrGain    = take && wbWeI && (idx == amcg_pkg::IDX_GAIN);
  assign wrIrqStat = take && wbWeI && (idx == amcg_pkg::IDX_IRQ_STAT);
  assign wrIrqMask = take && wbWeI && (idx == amcg_pkg::IDX_IRQ_MASK);

  always_comb
  begin
    mode_d  = mode_q;
    clock_d = clock_q;
    gain_d  = gain_q;
    if (wrMode)
    begin
      mode_d = amcgMerge(mode_q, wbDatI, wbSelI, amcg_pkg::MODE_WMASK);
      // Reset flag can only be cleared, never set by software
      mode_d[amcg_pkg::MODE_RSTSEEN] = mode_q[amcg_pkg::MODE_RSTSEEN]
                                       & mode_d[amcg_pkg::MODE_RSTSEEN];
    end
    if (wrClock)
    begin
      clock_d = amcgMerge(clock_q, wbDatI, wbSelI, amcg_pkg::CLOCK_WMASK);
    end
    if (wrGain)
    begin
      gain_d = amcgMerge(gain_q, wbDatI, wbSelI, amcg_pkg::GAIN_WMASK);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_q  <= amcg_pkg::MODE_RST;
      clock_q <= amcg_pkg::CLOCK_RST;
      gain_q  <= amcg_pkg::GAIN_RST;
    end
    else
    begin
      mode_q  <= mode_d;
      clock_q <= clock_d;
      gain_q  <= gain_d;
    end
  end

  always_comb
  begin
    unique case (amcg_pkg::amcg_wlen_e'(mode_d[amcg_pkg::MODE_WLEN_LSB +: 2]))
      amcg_pkg::WL_16:  wbits_d = amcg_pkg::WBITS_16;
      amcg_pkg::WL_24:  wbits_d = amcg_pkg::WBITS_24;
      default:          wbits_d = amcg_pkg::WBITS_32;
    endcase
  end

  // Decoded views registered alongside their fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      osr_q   <= amcg_pkg::OSR_BASE << amcg_pkg::CLOCK_RST[amcg_pkg::CLK_OSR_LSB +: 3];
      wbits_q <= amcg_pkg::WBITS_24;
    end
    else
    begin
      osr_q   <= amcg_pkg::OSR_BASE << clock_d[amcg_pkg::CLK_OSR_LSB +: 3];
      wbits_q <= wbits_d;
    end
  end

  // Read mux; status mirror carries crc type, reset flag and word length
  always_comb
  begin
    rdData = 32'h0000_0000;
    unique case (idx)
      amcg_pkg::IDX_STATUS:
        rdData[amcg_pkg::STAT_MIR_LSB +: 4] = mode_q[amcg_pkg::MODE_WLEN_LSB +: 4];
      amcg_pkg::IDX_MODE:     rdData[15:0] = mode_q;
      amcg_pkg::IDX_CLOCK:    rdData[15:0] = clock_q;
      amcg_pkg::IDX_GAIN:     rdData[15:0] = gain_q;
      amcg_pkg::IDX_IRQ_STAT: rdData[amcg_pkg::EV_W-1:0] = irqStat_q;
      amcg_pkg::IDX_IRQ_MASK: rdData[amcg_pkg::EV_W-1:0] = irqMask_q;
      default:                rdData = 32'h0000_0000;
    endcase
  end

  // Single-cycle answer; unmapped addresses ack with zero and drop writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_q   <= 1'b0;
      wbDat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= take;
      if (take && !wbWeI)
      begin
        wbDat_q <= rdData;
      end
    end
  end

  // Write events; a new event beats a same-cycle write-one clear
  assign events = {wrGain, wrClock, wrMode};

  always_comb
  begin
    irqStat_d = irqStat_q;
    if (wrIrqStat && wbSelI[0])
    begin
      irqStat_d = irqStat_q & ~wbDatI[amcg_pkg::EV_W-1:0];
    end
    irqStat_d = irqStat_d | events;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqStat_q <= '0;
      irqMask_q <= '0;
    end
    else
    begin
      irqStat_q <= irqStat_d;
      if (wrIrqMask && wbSelI[0])
      begin
        irqMask_q <= wbDatI[amcg_pkg::EV_W-1:0];
      end
    end
  end

  // Level from flops; one cycle behind the status bits it follows
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  // Data-ready pin: low when data waits, else high or floated
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdyO_q  <= 1'b1;
      rdyOe_q <= 1'b1;
    end
    else
    begin
      rdyO_q  <= !convDataAvail;
      rdyOe_q <= convDataAvail || !mode_q[amcg_pkg::MODE_FLOAT];
    end
  end

  assign wbDatO              = wbDat_q;
  assign wbAckO              = ack_q;
  assign dataReadyPinO       = rdyO_q;
  assign dataReadyPinOe      = rdyOe_q;
  assign regCrcOn            = mode_q[amcg_pkg::MODE_REGCRC];
  assign rxCrcOn             = mode_q[amcg_pkg::MODE_RXCRC];
  assign crcPolyAnsi         = mode_q[amcg_pkg::MODE_CRCTYPE];
  assign resetSeen           = mode_q[amcg_pkg::MODE_RSTSEEN];
  assign wordLengthSelect    = mode_q[amcg_pkg::MODE_WLEN_LSB +: 2];
  assign wordBits            = wbits_q;
  assign timeoutOn           = mode_q[amcg_pkg::MODE_TIMEOUT];
  assign readyPinFloatSelect = mode_q[amcg_pkg::MODE_FLOAT];
  assign channel0ConverterOn = clock_q[amcg_pkg::CLK_CHEN_LSB];
  assign channel1ConverterOn = clock_q[amcg_pkg::CLK_CHEN_LSB + 1];
  assign channel2ConverterOn = clock_q[amcg_pkg::CLK_CHEN_LSB + 2];
  assign channel3ConverterOn = clock_q[amcg_pkg::CLK_CHEN_LSB + 3];
  assign extClockSelect      = clock_q[amcg_pkg::CLK_SEL];
  assign oversamplingRatio   = clock_q[amcg_pkg::CLK_OSR_LSB +: 3];
  assign osrValue            = osr_q;
  assign powerModeSelect     = clock_q[amcg_pkg::CLK_PWR_LSB +: 2];
  // Codes 10b and 11b both mean high resolution
  assign highResolution      = clock_q[amcg_pkg::CLK_PWR_LSB + 1];
  assign ampGainCh0          = gain_q[0 +: 3];
  assign ampGainCh1          = gain_q[amcg_pkg::GAIN_STRIDE +: 3];
  assign ampGainCh2          = gain_q[2 * amcg_pkg::GAIN_STRIDE +: 3];
  assign ampGainCh3          = gain_q[3 * amcg_pkg::GAIN_STRIDE +: 3];
  assign irq                 = irq_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_wrModeHi;
    wrMode && wbSelI[1];
  endsequence

  sequence s_wrClockHi;
    wrClock && wbSelI[1];
  endsequence

  property p_modeRst;
    disable iff (1'b0) rst |=> mode_q == amcg_pkg::MODE_RST;
  endproperty
  a_modeRst: assert property (p_modeRst) else $error("mode reset value wrong");

  property p_regCrc;
    s_wrModeHi |=> regCrcOn == $past(wbDatI[amcg_pkg::MODE_REGCRC]);
  endproperty
  a_regCrc: assert property (p_regCrc) else $error("map crc enable not stored");

  property p_rxCrc;
    s_wrModeHi |=> rxCrcOn == $past(wbDatI[amcg_pkg::MODE_RXCRC]);
  endproperty
  a_rxCrc: assert property (p_rxCrc) else $error("frame crc enable not stored");

  property p_crcType;
    s_wrModeHi ##1 wbAckO |-> crcPolyAnsi == $past(wbDatI[amcg_pkg::MODE_CRCTYPE]);
  endproperty
  a_crcType: assert property (p_crcType) else $error("crc polynomial not stored");

  property p_rstSeenClr;
    s_wrModeHi |=> resetSeen == ($past(resetSeen) && $past(wbDatI[amcg_pkg::MODE_RSTSEEN]));
  endproperty
  a_rstSeenClr: assert property (p_rstSeenClr) else $error("reset flag update wrong");

  property p_rstSeenHold;
    !wrMode |=> $stable(resetSeen) || $past(rst);
  endproperty
  a_rstSeenHold: assert property (p_rstSeenHold) else $error("reset flag moved");

  property p_wlen;
    wrMode && wbSelI[1] |=> wordLengthSelect == $past(wbDatI[9:8])
                            ##1 wordBits == (wordLengthSelect == 2'h0 ? amcg_pkg::WBITS_16 :
                                             wordLengthSelect == 2'h1 ? amcg_pkg::WBITS_24 :
                                             amcg_pkg::WBITS_32);
  endproperty
  a_wlen: assert property (p_wlen) else $error("word length wrong");

  property p_timeout;
    wrMode && wbSelI[0] |=> timeoutOn == $past(wbDatI[amcg_pkg::MODE_TIMEOUT]);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout enable not stored");

  property p_rdyIdle;
    !convDataAvail |=> dataReadyPinOe == !$past(readyPinFloatSelect)
                       && (dataReadyPinO || !dataReadyPinOe);
  endproperty
  a_rdyIdle: assert property (p_rdyIdle) else $error("idle ready pin wrong");

  property p_clockRsvd;
    clock_q[15:12] == amcg_pkg::CLOCK_RSVD_HI;
  endproperty
  a_clockRsvd: assert property (p_clockRsvd) else $error("clock reserved bits set");

  property p_chanEn;
    s_wrClockHi |=> channel3ConverterOn == $past(wbDatI[11]) && channel0ConverterOn == $past(wbDatI[8]);
  endproperty
  a_chanEn: assert property (p_chanEn) else $error("channel enables not stored");

  property p_clkSel;
    wrClock && wbSelI[0] |=> extClockSelect == $past(wbDatI[amcg_pkg::CLK_SEL]);
  endproperty
  a_clkSel: assert property (p_clkSel) else $error("clock source not stored");

  property p_osr;
    osrValue == (amcg_pkg::OSR_BASE << oversamplingRatio);
  endproperty
  a_osr: assert property (p_osr) else $error("oversampling value wrong");

  property p_power;
    highResolution == (powerModeSelect >= 2'h2);
  endproperty
  a_power: assert property (p_power) else $error("power mode decode wrong");

  property p_gainRst;
    disable iff (1'b0) rst |=> gain_q == amcg_pkg::GAIN_RST;
  endproperty
  a_gainRst: assert property (p_gainRst) else $error("gain reset value wrong");

  property p_gain;
    wrGain && wbSelI[1] |=> ampGainCh3 == $past(wbDatI[14:12]) && ampGainCh2 == $past(wbDatI[10:8]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain code not stored");

  property p_statMirror;
    take && !wbWeI && idx == amcg_pkg::IDX_STATUS
      |=> wbDatO[11:8] == $past(mode_q[11:8]) && wbAckO;
  endproperty
  a_statMirror: assert property (p_statMirror) else $error("status mirror wrong");

  property p_rsvdZero;
    (gain_q & ~amcg_pkg::GAIN_WMASK) == 16'h0000 && (mode_q & ~amcg_pkg::MODE_WMASK) == 16'h0000;
  endproperty
  a_rsvdZero: assert property (p_rsvdZero) else $error("reserved bits stored");

  property p_ackPulse;
    wbAckO |=> !wbAckO;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack held two cycles");

  property p_irq;
    ##1 irq == $past(|(irqStat_q & irqMask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");

endmodule

/* verif/amcg_host_model.sv */
/*
  Host-side classic Wishbone master model for the mode/clock/gain register bank.
  Assumes each task call starts right after a rising edge of mclk.
*/
`timescale 1ns/100ps

module amcg_host_model (
  input  wire logic        mclk,
  output logic             wbCyc,
  output logic             wbStb,
  output logic             wbWe,
  output logic [7:0]       wbAdr,
  output logic [3:0]       wbSel,
  output logic [31:0]      wbDat,
  input  wire logic        wbAck,
  input  wire logic [31:0] wbRdat
);
  initial
  begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe  = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDat = 32'h0000_0000;
  end

  // No limit of its own; a slave that never answers is caught by the bench watchdog
  task automatic busCycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [15:0] wd, output logic [31:0] rd);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDat <= {16'h0000, wd};
    do
    begin
      @(posedge mclk);
    end
    while (wbAck !== 1'b1);
    rd = wbRdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    // Released lines except wbSel carry no stale value
    wbWe  <= ~we;
    wbAdr <= ~adr;
    wbDat <= ~{16'h0000, wd};
    @(posedge mclk);
  endtask
endmodule

/* verif/amcg_regs_tb.sv */
/*
  Self-checking bench for the mode/clock/gain register bank: reset values, field
  decodes, byte lanes, reserved bits, write-event interrupts and data-ready pin.
  Assumes the host model carries all bus traffic; 100 MHz clock.
*/
`timescale 1ns/100ps

module amcg_regs_tb;
  logic        mclk, rst, convDataAvail;
  logic        wbCyc, wbStb, wbWe, wbAck, irq;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDat, wbRdat;
  logic        dataReadyPinO, dataReadyPinOe, regCrcOn, rxCrcOn, crcPolyAnsi, resetSeen;
  logic        timeoutOn, readyPinFloatSelect, extClockSelect, highResolution;
  logic        channel0ConverterOn, channel1ConverterOn, channel2ConverterOn;
  logic        channel3ConverterOn;
  logic [1:0]  wordLengthSelect, powerModeSelect;
  logic [5:0]  wordBits;
  logic [2:0]  oversamplingRatio, ampGainCh0, ampGainCh1, ampGainCh2, ampGainCh3;
  logic [14:0] osrValue;
  logic [15:0] modeS, clockS, gainS;
  logic [2:0]  evS, maskS, c;
  int          bad_count, total_checks;
  logic [7:0]  adrTab [6] = '{8'h08, 8'h0c, 8'h10, 8'h40, 8'h44, 8'h14};

  amcg_host_model host (.mclk, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDat, .wbAck, .wbRdat);
  amcg_regs DUT (
    .mclk, .rst, .wbCycI(wbCyc), .wbStbI(wbStb), .wbWeI(wbWe), .wbAdrI(wbAdr), .wbSelI(wbSel),
    .wbDatI(wbDat), .wbDatO(wbRdat), .wbAckO(wbAck), .convDataAvail, .dataReadyPinO,
    .dataReadyPinOe, .regCrcOn, .rxCrcOn, .crcPolyAnsi, .resetSeen, .wordLengthSelect,
    .wordBits, .timeoutOn, .readyPinFloatSelect, .channel0ConverterOn, .channel1ConverterOn,
    .channel2ConverterOn, .channel3ConverterOn, .extClockSelect, .oversamplingRatio, .osrValue,
    .powerModeSelect, .highResolution, .ampGainCh0, .ampGainCh1, .ampGainCh2, .ampGainCh3, .irq
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  function automatic logic [15:0] upd(input logic [15:0] old, d, input logic [1:0] s,
                                      input logic [15:0] wm, input logic isMode);
    logic [15:0] m;
    logic [15:0] e;
    m = {{8{s[1]}}, {8{s[0]}}};
    e = ((old & ~m) | (d & m)) & wm;
    if (isMode)
      e[10] = old[10] & e[10];
    return e;
  endfunction

  function automatic logic [5:0] expBits(input logic [1:0] w);
    return (w == 2'h0) ? 6'h10 : (w == 2'h1) ? 6'h18 : 6'h20;
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    logic [31:0] rd;
    host.busCycle(1'b1, a, s, d, rd);
    if (a == 8'h08)
      modeS = upd(modeS, d, s[1:0], 16'h3f12, 1'b1);
    if (a == 8'h0c)
      clockS = upd(clockS, d, s[1:0], 16'h0f9f, 1'b0);
    if (a == 8'h10)
      gainS = upd(gainS, d, s[1:0], 16'h7777, 1'b0);
    if (a inside {8'h08, 8'h0c, 8'h10})
      evS[a[4:2] - 3'h2] = 1'b1;
    if (a == 8'h40 && s[0])
      evS = evS & ~d[2:0];
    if (a == 8'h44 && s[0])
      maskS = d[2:0];
  endtask

  task automatic rdChk(input string n, input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] rd;
    host.busCycle(1'b0, a, 4'hf, 16'h0000, rd);
    chk(n, rd, {16'h0000, exp});
  endtask

  task automatic checkState();
    rdChk("mode", 8'h08, modeS);
    rdChk("clock", 8'h0c, clockS);
    rdChk("gain", 8'h10, gainS);
    rdChk("status", 8'h04, {4'h0, modeS[11:8], 8'h00});
    rdChk("evStat", 8'h40, {13'h0000, evS});
    rdChk("evMask", 8'h44, {13'h0000, maskS});
    rdChk("unmapped", 8'h14, 16'h0000);
    chk("modeOut", {regCrcOn, rxCrcOn, crcPolyAnsi, resetSeen, wordLengthSelect,
        timeoutOn, readyPinFloatSelect}, {modeS[13:8], modeS[4], modeS[1]});
    chk("wordBits", wordBits, expBits(modeS[9:8]));
    chk("chanOn", {channel3ConverterOn, channel2ConverterOn, channel1ConverterOn,
        channel0ConverterOn}, clockS[11:8]);
    chk("clkOut", {extClockSelect, oversamplingRatio, powerModeSelect, highResolution},
        {clockS[7], clockS[4:0], clockS[1]});
    chk("osr", osrValue, 15'h0080 << clockS[4:2]);
    chk("gains", {ampGainCh3, ampGainCh2, ampGainCh1, ampGainCh0},
        {gainS[14:12], gainS[10:8], gainS[6:4], gainS[2:0]});
    chk("irq", irq, |(evS & maskS));
  endtask

  task automatic doReset();
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    modeS = 16'h0510;
    clockS = 16'h0f8e;
    gainS = 16'h0000;
    evS = 3'h0;
    maskS = 3'h0;
  endtask

  task automatic pinChk(input logic avail, input logic flt);
    wr(8'h08, 4'h1, {8'h00, modeS[7:2], flt, 1'b0});
    convDataAvail <= avail;
    repeat (2) @(posedge mclk);
    chk("drPin", {dataReadyPinO, dataReadyPinOe}, avail ? 2'h1 : (flt ? 2'h2 : 2'h3));
  endtask

  initial
  begin
    rst = 1'b1;
    convDataAvail = 1'b0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'hd5f8));
    doReset();
    chk("rstDecode", {wordBits, osrValue, dataReadyPinO, dataReadyPinOe},
        {6'h18, 15'h0400, 2'h3});
    checkState();
    $display("test reset done");
    wr(8'h08, 4'h3, 16'h0110);
    for (int k = 0; k < 8; k++)
    begin
      c = k[2:0];
      wr(8'h08, 4'h3, {2'h0, c, 1'b1, c[1:0], 3'h0, c[0], 2'h0, c[1], 1'b0});
      wr(8'h0c, 4'h3, {4'hf, 1'b0, c, 1'b1, 2'h3, c, c[1:0]});
      wr(8'h10, 4'h3, {1'b1, c, 1'b1, c, 1'b1, c, 1'b1, c});
      checkState();
    end
    $display("test field table done");
    wr(8'h40, 4'h1, 16'h0007);
    wr(8'h0c, 4'h3, clockS);
    checkState();
    wr(8'h44, 4'h1, 16'h0002);
    checkState();
    wr(8'h40, 4'h1, 16'h0002);
    checkState();
    $display("test interrupt done");
    for (int k = 0; k < 4; k++)
      pinChk(k[1], k[0]);
    $display("test data-ready pin done");
    for (int k = 0; k < 60; k++)
    begin
      wr(adrTab[$urandom_range(5, 0)], 4'($urandom), 16'($urandom));
      if (k % 6 == 5)
        checkState();
    end
    $display("test random done");
    doReset();
    checkState();
    $display("test mid-run reset done");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end
endmodule
